// ===== core/ocr_pkg.sv
// Purpose: shared constants for the character attribute renderer
// Assumes: 32-bit AXI4-Lite register access, 4-bit colour table index
// Notes:   offsets are byte addresses of aligned words
package ocr_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0] OCR_OFF_CTRL   = 8'h00;
	localparam logic [7:0] OCR_OFF_PAGE   = 8'h04;
	localparam logic [7:0] OCR_OFF_CURSOR = 8'h08;
	localparam logic [7:0] OCR_OFF_FRINGE = 8'h0c;
	localparam logic [7:0] OCR_OFF_STATUS = 8'h10;
	// ctrl fields
	localparam int OCR_CTRL_TELETEXT = 0;
	localparam int OCR_CTRL_DOUBLE   = 1;
	localparam int OCR_CTRL_ACTPAGE  = 2;
	localparam int OCR_CTRL_MESH     = 3;
	localparam int OCR_CTRL_CURSOR   = 4;
	localparam int OCR_CTRL_HOLD     = 5;
	localparam int OCR_CTRL_REDEFEXT = 6;
	localparam int OCR_CTRL_CCFRINGE = 7;
	// page fields
	localparam int OCR_PAGE_FRINGE_A = 0;
	localparam int OCR_PAGE_FRINGE_B = 1;
	localparam int OCR_PAGE_BMESH_A  = 2;
	localparam int OCR_PAGE_BMESH_B  = 3;
	localparam int OCR_PAGE_CMESH_A  = 4;
	localparam int OCR_PAGE_CMESH_B  = 5;
	localparam int OCR_PAGE_REDEF_A  = 6;
	localparam int OCR_PAGE_REDEF_B  = 7;
	// cursor fields: row in [4:0], column in [13:8]
	localparam int OCR_CUR_COL_LSB = 8;
	// caption serial word fields
	localparam int OCR_SER_UNDER = 4;
	localparam int OCR_SER_OVER  = 5;
	localparam int OCR_SER_ITAL  = 6;
	localparam int OCR_SER_BANK  = 7;
	localparam int OCR_SER_BGDUR = 8;
	localparam int OCR_SER_EOR   = 9;
	localparam int OCR_SER_MODE  = 10;
	localparam int OCR_SER_FLAG  = 11;
	// reset values
	localparam logic [31:0] OCR_CTRL_RST   = 32'h0000_0000;
	localparam logic [31:0] OCR_PAGE_RST   = 32'h0000_0000;
	localparam logic [31:0] OCR_CURSOR_RST = 32'h0000_0000;
	localparam logic [31:0] OCR_FRINGE_RST = 32'h0000_0000;
	// colours and teletext codes
	localparam logic [3:0] OCR_TT_FG_DEFAULT = 4'h7;
	localparam logic [3:0] OCR_TT_BG_DEFAULT = 4'h8;
	localparam logic [3:0] OCR_CC_BG_DEFAULT = 4'h0;
	localparam logic [3:0] OCR_BLACK_BG      = 4'h8;
	localparam logic [7:0] OCR_TT_NEW_BG     = 8'h1d;
	localparam logic [7:0] OCR_TT_GFX_LO     = 8'h10;
	localparam logic [7:0] OCR_TT_GFX_HI     = 8'h17;
	localparam logic [7:0] OCR_TT_ALPHA_HI   = 8'h07;
	// limits
	localparam logic [5:0] OCR_TT_ROW_LEN = 6'h28;
	localparam logic [4:0] OCR_CC_ROW_MAX = 5'h0f;
	localparam logic [5:0] OCR_CC_COL_MAX = 6'h2f;
	localparam logic [4:0] OCR_TT_ROW_MAX = 5'h18;
	localparam logic [5:0] OCR_TT_COL_MAX = 6'h27;
	// redefinable character code blocks
	localparam logic [3:0] OCR_REDEF_BASE = 4'h8;
	localparam logic [3:0] OCR_REDEF_EXT1 = 4'ha;
	localparam logic [3:0] OCR_REDEF_EXT2 = 4'hc;
endpackage

// ===== core/ocr_render.sv
// Purpose: attribute state, colour resolution and register file of the renderer
// Assumes: one pixel per clock, cell_start marks the first pixel of each cell
// Notes:   colour output lags the pixel inputs by two clocks
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module ocr_render
	import ocr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// pixel stream from the display timing
	input  wire logic        pix_valid,
	input  wire logic        row_start,
	input  wire logic        cell_start,
	input  wire logic [14:0] char_word,
	input  wire logic        glyph_on,
	input  wire logic [3:0]  fringe_nbr,
	input  wire logic        scan_top,
	input  wire logic        scan_bottom,
	input  wire logic        scan_odd,
	input  wire logic        pix_odd,
	input  wire logic [4:0]  cell_row,
	input  wire logic [5:0]  cell_col,
	input  wire logic        page_b,
	input  wire logic        text_area_end,
	// outputs to the display path and glyph fetch
	output logic [3:0]       pix_colour_q,
	output logic             pix_video_q,
	output logic             pix_valid_q,
	output logic             redef_sel_q,
	output logic [5:0]       redef_index_q
);
	// ==========================================================
	// register file
	logic [31:0] ctrl_q, page_q, cursor_q, fringe_q;
	logic        wr_go, rd_hit, wr_hit;
	logic [31:0] rd_word;
	logic [31:0] wmask;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{s_axi_wstrb[i]}};
		end
	end

	// write address and data are taken together
	assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_arready = ~s_axi_rvalid;
	assign wr_hit = (s_axi_awaddr == OCR_OFF_CTRL) | (s_axi_awaddr == OCR_OFF_PAGE)
		| (s_axi_awaddr == OCR_OFF_CURSOR) | (s_axi_awaddr == OCR_OFF_FRINGE);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl_q   <= OCR_CTRL_RST;
			page_q   <= OCR_PAGE_RST;
			cursor_q <= OCR_CURSOR_RST;
			fringe_q <= OCR_FRINGE_RST;
		end else if (wr_go) begin
			unique case (s_axi_awaddr)
				OCR_OFF_CTRL:   ctrl_q   <= (ctrl_q & ~wmask) | (s_axi_wdata & wmask);
				OCR_OFF_PAGE:   page_q   <= (page_q & ~wmask) | (s_axi_wdata & wmask);
				OCR_OFF_CURSOR: cursor_q <= (cursor_q & ~wmask) | (s_axi_wdata & wmask);
				OCR_OFF_FRINGE: fringe_q <= (fringe_q & ~wmask) | (s_axi_wdata & wmask);
				default: ;
			endcase
		end
	end

	// write response, slverr on unmapped
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// attribute state per row
	logic       tt;
	logic [3:0] fg_q, fg_d, bg_q, bg_d, fgp_q, fgp_d, bgp_q, bgp_d;
	logic       fgp_v_q, fgp_v_d, bgp_v_q, bgp_v_d, bank_q, bank_d, bankp_q, bankp_d;
	logic       ul_q, ul_d, ol_q, ol_d, ital_q, ital_d, bgdur_q, bgdur_d;
	logic       eorp_q, eorp_d, done_q, done_d, gfx_q, gfx_d, gfxp_q, gfxp_d;
	logic [5:0] ncell_q, ncell_d;
	logic [7:0] code;

	assign tt   = ctrl_q[OCR_CTRL_TELETEXT];
	assign code = char_word[7:0];

	always_comb begin
		{fg_d, bg_d, fgp_d, bgp_d} = {fg_q, bg_q, fgp_q, bgp_q};
		{fgp_v_d, bgp_v_d, bank_d, bankp_d} = {fgp_v_q, bgp_v_q, bank_q, bankp_q};
		{ul_d, ol_d, ital_d, bgdur_d} = {ul_q, ol_q, ital_q, bgdur_q};
		{eorp_d, done_d, gfx_d, gfxp_d, ncell_d} = {eorp_q, done_q, gfx_q, gfxp_q, ncell_q};
		if (pix_valid & cell_start) begin
			if (row_start) begin
				// row defaults
				fg_d    = tt ? OCR_TT_FG_DEFAULT : 4'h0;
				bg_d    = tt ? OCR_TT_BG_DEFAULT : OCR_CC_BG_DEFAULT;
				{ul_d, ol_d, ital_d, bgdur_d, eorp_d, done_d} = 6'h00;
				// a pending bank choice from the last row must not leak into this one
				{fgp_v_d, bgp_v_d, bank_d, bankp_d, gfx_d, gfxp_d} = 6'h00;
				ncell_d = 6'h00;
			end else begin
				// set-after values from the previous cell take hold now
				if (fgp_v_q) begin
					fg_d  = fgp_q;
					gfx_d = gfxp_q;
				end
				if (bgp_v_q) begin
					bg_d = bgp_q;
				end
				bank_d  = bankp_q;
				done_d  = done_q | eorp_q | (tt & (ncell_q >= OCR_TT_ROW_LEN));
				fgp_v_d = 1'b0;
				bgp_v_d = 1'b0;
			end
			if (ncell_d != 6'h3f) begin
				ncell_d = ncell_d + 6'h01;
			end
			if (tt) begin
				if (code <= OCR_TT_ALPHA_HI) begin
					fgp_d   = {1'b0, code[2:0]};
					fgp_v_d = 1'b1;
					gfxp_d  = 1'b0;
				end else if (code >= OCR_TT_GFX_LO && code <= OCR_TT_GFX_HI) begin
					fgp_d   = {1'b0, code[2:0]};
					fgp_v_d = 1'b1;
					gfxp_d  = 1'b1;
				end else if (code == OCR_TT_NEW_BG) begin
					bg_d = {1'b1, fg_d[2:0]};
				end
			end else if (char_word[OCR_SER_FLAG]) begin
				ul_d    = char_word[OCR_SER_UNDER];
				ol_d    = char_word[OCR_SER_OVER];
				ital_d  = char_word[OCR_SER_ITAL];
				bgdur_d = char_word[OCR_SER_BGDUR];
				eorp_d  = eorp_d | char_word[OCR_SER_EOR];
				if (char_word[OCR_SER_MODE]) begin
					bgp_d   = char_word[3:0];
					bgp_v_d = 1'b1;
					bankp_d = char_word[OCR_SER_BANK];
				end else begin
					bg_d = char_word[3:0];
				end
			end else begin
				fg_d = {bank_d, char_word[10:8]};
			end
		end
	end

	// attribute registers advance once per cell
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			{fg_q, bg_q, fgp_q, bgp_q} <= 16'h0000;
			{fgp_v_q, bgp_v_q, bank_q, bankp_q} <= 4'h0;
			{ul_q, ol_q, ital_q, bgdur_q} <= 4'h0;
			{eorp_q, done_q, gfx_q, gfxp_q} <= 4'h0;
			ncell_q <= 6'h00;
		end else begin
			{fg_q, bg_q, fgp_q, bgp_q} <= {fg_d, bg_d, fgp_d, bgp_d};
			{fgp_v_q, bgp_v_q, bank_q, bankp_q} <= {fgp_v_d, bgp_v_d, bank_d, bankp_d};
			{ul_q, ol_q, ital_q, bgdur_q} <= {ul_d, ol_d, ital_d, bgdur_d};
			{eorp_q, done_q, gfx_q, gfxp_q} <= {eorp_d, done_d, gfx_d, gfxp_d};
			ncell_q <= ncell_d;
		end
	end

	// ==========================================================
	// pixel stage one: hold pixel inputs beside the updated attributes
	logic       p_v, p_glyph, p_top, p_bot, p_odd, p_pageb, p_tae, p_serial;
	logic [3:0] p_nbr;
	logic [4:0] p_row, cur_row_q;
	logic [5:0] p_col, cur_col_q;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			{p_v, p_glyph, p_top, p_bot, p_odd, p_pageb, p_tae, p_serial} <= 8'h00;
			p_nbr <= 4'h0;
			p_row <= 5'h00;
			p_col <= 6'h00;
		end else begin
			p_v      <= pix_valid;
			p_glyph  <= glyph_on;
			p_top    <= scan_top;
			p_bot    <= scan_bottom;
			p_odd    <= scan_odd ^ pix_odd;
			p_pageb  <= page_b & ctrl_q[OCR_CTRL_DOUBLE];
			p_tae    <= text_area_end;
			p_serial <= cell_start ? (~tt & char_word[OCR_SER_FLAG]) : p_serial;
			p_nbr    <= fringe_nbr;
			p_row    <= cell_row;
			p_col    <= cell_col;
		end
	end

	// cursor position, frozen while hold is set
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cur_row_q <= 5'h00;
			cur_col_q <= 6'h00;
		end else if (!ctrl_q[OCR_CTRL_HOLD]) begin
			cur_row_q <= cursor_q[4:0];
			cur_col_q <= cursor_q[OCR_CUR_COL_LSB +: 6];
		end
	end

	// ==========================================================
	// colour resolution
	logic       active, cur_ok, cur_hit, fr_en, fr_hit, mesh_on, line_hit, shown, fill;
	logic [3:0] fg_e, bg_e, colour_d;
	logic       video_d;

	assign active = ctrl_q[OCR_CTRL_DOUBLE] ? (p_pageb == ctrl_q[OCR_CTRL_ACTPAGE]) : 1'b1;
	assign cur_ok = tt ? (cur_row_q <= OCR_TT_ROW_MAX && cur_col_q <= OCR_TT_COL_MAX)
		: (cur_row_q <= OCR_CC_ROW_MAX && cur_col_q <= OCR_CC_COL_MAX);
	assign cur_hit = ctrl_q[OCR_CTRL_CURSOR] & active & cur_ok
		& (p_row == cur_row_q) & (p_col == cur_col_q);
	assign fg_e = cur_hit ? bg_q : fg_q;
	assign bg_e = cur_hit ? fg_q : bg_q;
	assign fr_en = tt ? (~gfx_q & page_q[p_pageb ? OCR_PAGE_FRINGE_B : OCR_PAGE_FRINGE_A])
		: ctrl_q[OCR_CTRL_CCFRINGE];
	assign fr_hit = fr_en & |(p_nbr & fringe_q[3:0]);
	assign mesh_on = tt ? ((bg_e == OCR_BLACK_BG)
		? page_q[p_pageb ? OCR_PAGE_BMESH_B : OCR_PAGE_BMESH_A]
		: (bg_e[3] & page_q[p_pageb ? OCR_PAGE_CMESH_B : OCR_PAGE_CMESH_A]))
		: ctrl_q[OCR_CTRL_MESH];
	assign line_hit = ~tt & ((ul_q & p_bot) | (ol_q & ~ital_q & p_top));
	assign fill  = ~tt & bgdur_q & (eorp_q | done_q) & ~p_tae;
	assign shown = ~done_q;

	always_comb begin
		colour_d = bg_e;
		video_d  = 1'b0;
		if (shown) begin
			if (p_glyph & ~p_serial) begin
				colour_d = fg_e;
			end else if (line_hit) begin
				colour_d = fg_e;
			end else if (fr_hit & ~p_serial) begin
				colour_d = fringe_q[7:4];
			end else begin
				video_d = mesh_on & p_odd;
			end
		end else if (fill) begin
			// past end-of-row: background and lines run on to the text-area end
			colour_d = line_hit ? fg_e : bg_e;
			video_d  = ~line_hit & mesh_on & p_odd;
		end else begin
			video_d = 1'b1;
		end
	end

	// pixel stage two: registered colour out
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pix_colour_q <= 4'h0;
			pix_video_q  <= 1'b1;
			pix_valid_q  <= 1'b0;
		end else begin
			pix_colour_q <= colour_d;
			pix_video_q  <= video_d;
			pix_valid_q  <= p_v;
		end
	end

	// ==========================================================
	// redefinable character remap, one 12x16 glyph per index
	logic       redef_en, redef_hit;
	logic [1:0] redef_blk;

	assign redef_en = page_q[(page_b & ctrl_q[OCR_CTRL_DOUBLE])
		? OCR_PAGE_REDEF_B : OCR_PAGE_REDEF_A];
	always_comb begin
		redef_blk = 2'b00;
		redef_hit = 1'b0;
		if (code[7:4] == OCR_REDEF_BASE) begin
			redef_hit = 1'b1;
		end else if (ctrl_q[OCR_CTRL_REDEFEXT] && code[7:4] == OCR_REDEF_EXT1) begin
			redef_blk = 2'b01;
			redef_hit = 1'b1;
		end else if (ctrl_q[OCR_CTRL_REDEFEXT] && code[7:4] == OCR_REDEF_EXT2) begin
			redef_blk = 2'b10;
			redef_hit = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			redef_sel_q   <= 1'b0;
			redef_index_q <= 6'h00;
		end else if (pix_valid & cell_start) begin
			redef_sel_q   <= redef_en & redef_hit;
			redef_index_q <= {redef_blk, code[3:0]};
		end
	end

	// ==========================================================
	// read path
	assign rd_hit = (s_axi_araddr == OCR_OFF_CTRL) | (s_axi_araddr == OCR_OFF_PAGE)
		| (s_axi_araddr == OCR_OFF_CURSOR) | (s_axi_araddr == OCR_OFF_FRINGE)
		| (s_axi_araddr == OCR_OFF_STATUS);
	always_comb begin
		unique case (s_axi_araddr)
			OCR_OFF_CTRL:   rd_word = ctrl_q;
			OCR_OFF_PAGE:   rd_word = page_q;
			OCR_OFF_CURSOR: rd_word = cursor_q;
			OCR_OFF_FRINGE: rd_word = fringe_q;
			OCR_OFF_STATUS: rd_word = {2'b00, cur_col_q, 7'h00, cur_row_q,
				2'b00, gfx_q, done_q, bg_q, fg_q};
			default:        rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'b00;
		end else if (s_axi_arvalid & ~s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// checks
	logic cs;
	assign cs = pix_valid & cell_start & ~row_start;

	tt_fg_after_a: assert property (@(posedge clock) disable iff (sys_rst)
		cs & tt & (code <= OCR_TT_ALPHA_HI) |=> (fg_q == $past(fgp_v_q ? fgp_q : fg_q))
		& (fgp_q == $past(code[3:0])))
		else $error("teletext foreground changed at its own cell");
	tt_newbg_a: assert property (@(posedge clock) disable iff (sys_rst)
		cs & tt & (code == OCR_TT_NEW_BG) |=> bg_q == {1'b1, fg_q[2:0]})
		else $error("new background not taken from foreground");
	tt_row_def_a: assert property (@(posedge clock) disable iff (sys_rst)
		pix_valid & cell_start & row_start & tt & (code > OCR_TT_NEW_BG) |=>
		(fg_q == OCR_TT_FG_DEFAULT) & (bg_q == OCR_TT_BG_DEFAULT))
		else $error("teletext row defaults wrong");
	cc_row_def_a: assert property (@(posedge clock) disable iff (sys_rst)
		pix_valid & cell_start & row_start & ~tt & ~char_word[OCR_SER_FLAG] |=>
		~ul_q & ~ol_q & ~bgdur_q & ~eorp_q & ~done_q)
		else $error("caption row defaults wrong");
	cc_bg_mode1_a: assert property (@(posedge clock) disable iff (sys_rst)
		cs & ~tt & char_word[OCR_SER_FLAG] & char_word[OCR_SER_MODE] |=> bgp_v_q
		& (bgp_q == $past(char_word[3:0])) & (bg_q == $past(bgp_v_q ? bgp_q : bg_q)))
		else $error("set-after background taken at its own cell");
	cursor_swap_a: assert property (@(posedge clock) disable iff (sys_rst)
		shown & cur_hit & p_glyph & ~p_serial |=> pix_colour_q == $past(bg_q))
		else $error("cursor did not swap colours");
	cursor_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		ctrl_q[OCR_CTRL_HOLD] |=> $stable(cur_row_q) & $stable(cur_col_q))
		else $error("cursor moved while held");
	tt_len_a: assert property (@(posedge clock) disable iff (sys_rst)
		cs & tt & (ncell_q >= OCR_TT_ROW_LEN) |=> done_q ##1 pix_video_q)
		else $error("teletext row exceeded forty cells");
	overline_a: assert property (@(posedge clock) disable iff (sys_rst)
		shown & ~tt & ital_q & p_top & ~ul_q & ~p_glyph & ~fr_hit |=> pix_colour_q == $past(bg_e))
		else $error("overline drawn on italic");
	redef_a: assert property (@(posedge clock) disable iff (sys_rst)
		pix_valid & cell_start & (code[7:4] == OCR_REDEF_EXT1) & ~ctrl_q[OCR_CTRL_REDEFEXT]
		|=> ~redef_sel_q)
		else $error("extension codes remapped without extension");

	tt_new_bg_c: cover property (@(posedge clock) cs & tt & (code == OCR_TT_NEW_BG));
	cc_eor_fill_c: cover property (@(posedge clock) fill & p_v);
	cursor_c: cover property (@(posedge clock) cur_hit & p_v);
endmodule

// ===== tb/ocr_tv_sink.sv
// Purpose: display path model that takes the rendered pixels
// Assumes: a pixel is delivered on each edge where pix_valid_q is high
// Notes:   keeps the last pixel and a running pixel count for the bench
`timescale 1ns/1ps
module ocr_tv_sink (
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       pix_valid_q,
	input  wire logic [3:0] pix_colour_q,
	input  wire logic       pix_video_q,
	output int              n_pix,
	output logic [3:0]      colour,
	output logic            video
);
	// ==========================================================
	// pixel capture
	// only qualified pixels are taken, the rest of the stream is ignored
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			n_pix <= 0;
		end else if (pix_valid_q) begin
			n_pix  <= n_pix + 1;
			colour <= pix_colour_q;
			video  <= pix_video_q;
		end
	end
endmodule

// ===== tb/osd_char_attribute_render_bench.sv
// Purpose: self-checking bench for the character attribute renderer
// Assumes: one pixel is sent, then the bench waits for it at the display model
// Notes:   expected colours are table indices worked out per scenario
`timescale 1ns/1ps
`define CK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module osd_char_attribute_render_bench;
	import ocr_pkg::*;
	logic clock, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, pix_valid, row_start, cell_start, glyph_on, scan_top;
	logic scan_bottom, scan_odd, pix_odd, page_b, text_area_end, pix_video_q;
	logic pix_valid_q, redef_sel_q, tv_video;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, fringe_nbr, pix_colour_q, tv_colour;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [14:0] char_word;
	logic [4:0] cell_row;
	logic [5:0] cell_col, redef_index_q;
	int n_pix, n_fail, check_count;
	ocr_render dut (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pix_valid, .row_start,
		.cell_start, .char_word, .glyph_on, .fringe_nbr, .scan_top, .scan_bottom,
		.scan_odd, .pix_odd, .cell_row, .cell_col, .page_b, .text_area_end, .pix_colour_q,
		.pix_video_q, .pix_valid_q, .redef_sel_q, .redef_index_q);
	ocr_tv_sink u_tv (.clock, .sys_rst, .pix_valid_q, .pix_colour_q, .pix_video_q,
		.n_pix, .colour(tv_colour), .video(tv_video));
	// ==========================================================
	// clock and verdict
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	task automatic conclude();
		$display("checks=%0d failures=%0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		conclude();
	end
	// ==========================================================
	// register bus tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge clock); while (!s_axi_awready);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge clock); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		`CK(s_axi_bresp, 2'b00)
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clock); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clock); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		`CK(s_axi_rdata, ed)
		`CK(s_axi_rresp, er)
	endtask
	// one pixel; f is {scan_odd, scan_bottom, scan_top, glyph_on, cell_start, row_start}
	// a meshed pixel shows video, so its colour is not compared
	task automatic px(input logic [5:0] f, input logic [14:0] w, input logic [3:0] ec,
		input logic ev);
		int n;
		n = n_pix;
		@(posedge clock);
		{scan_odd, scan_bottom, scan_top, glyph_on, cell_start, row_start} <= f;
		char_word <= w;
		pix_valid <= 1'b1;
		@(posedge clock);
		pix_valid <= 1'b0;
		{cell_start, row_start} <= 2'b00;
		// the display model bumps its count by non-blocking assignment, seen one edge on
		do @(posedge clock); while (n_pix == n);
		`CK(tv_video, ev)
		if (!ev) `CK(tv_colour, ec)
	endtask
	// ==========================================================
	// test sequence
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{pix_valid, row_start, cell_start, glyph_on, scan_top, scan_bottom} = '0;
		{scan_odd, pix_odd, page_b, text_area_end, fringe_nbr, cell_row, cell_col} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, char_word} = '0;
		s_axi_wstrb = 4'hf;
		n_fail = 0;
		check_count = 0;
		sys_rst = 1'b1;
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		rd(OCR_OFF_CTRL, OCR_CTRL_RST, 2'b00);
		rd(OCR_OFF_FRINGE, OCR_FRINGE_RST, 2'b00);
		rd(8'h14, 32'h0, 2'b10);
		// caption colours, serial timing and lines
		px(6'h07, 15'h0341, 4'h3, 1'b0);
		px(6'h02, 15'h0805, 4'h5, 1'b0);
		px(6'h02, 15'h0c89, 4'h5, 1'b0);
		px(6'h06, 15'h0241, 4'ha, 1'b0);
		px(6'h00, 15'h0241, 4'h9, 1'b0);
		px(6'h02, 15'h0819, 4'h9, 1'b0);
		px(6'h12, 15'h0241, 4'ha, 1'b0);
		px(6'h02, 15'h0869, 4'h9, 1'b0);
		px(6'h0a, 15'h0241, 4'h9, 1'b0);
		px(6'h02, 15'h0829, 4'h9, 1'b0);
		px(6'h0a, 15'h0241, 4'ha, 1'b0);
		px(6'h0b, 15'h0241, 4'h0, 1'b0);
		// caption end-of-row with and without background duration, space after it
		px(6'h03, 15'h0b05, 4'h5, 1'b0);
		px(6'h02, 15'h0020, 4'h5, 1'b0);
		text_area_end <= 1'b1;
		px(6'h00, 15'h0020, 4'h0, 1'b1);
		text_area_end <= 1'b0;
		px(6'h03, 15'h0a05, 4'h5, 1'b0);
		px(6'h02, 15'h0020, 4'h0, 1'b1);
		// caption mesh
		wr(OCR_OFF_CTRL, 32'h08);
		px(6'h23, 15'h0805, 4'h0, 1'b1);
		px(6'h00, 15'h0805, 4'h5, 1'b0);
		// cursor swap and hold
		wr(OCR_OFF_CURSOR, 32'h0302);
		wr(OCR_OFF_CTRL, 32'h10);
		cell_row <= 5'h2;
		cell_col <= 6'h3;
		px(6'h07, 15'h0341, 4'h0, 1'b0);
		px(6'h00, 15'h0341, 4'h3, 1'b0);
		cell_col <= 6'h4;
		px(6'h06, 15'h0341, 4'h3, 1'b0);
		wr(OCR_OFF_CTRL, 32'h30);
		wr(OCR_OFF_CURSOR, 32'h0404);
		rd(OCR_OFF_CURSOR, 32'h0404, 2'b00);
		px(6'h06, 15'h0341, 4'h3, 1'b0);
		cell_col <= 6'h3;
		px(6'h06, 15'h0341, 4'h0, 1'b0);
		// redefinable character remapping
		wr(OCR_OFF_CTRL, 32'h00);
		wr(OCR_OFF_PAGE, 32'h40);
		px(6'h07, 15'h0085, 4'h0, 1'b0);
		`CK({redef_sel_q, redef_index_q}, 7'h45)
		px(6'h06, 15'h00a3, 4'h0, 1'b0);
		`CK(redef_sel_q, 1'b0)
		wr(OCR_OFF_CTRL, 32'h40);
		px(6'h06, 15'h00a3, 4'h0, 1'b0);
		`CK({redef_sel_q, redef_index_q}, 7'h53)
		px(6'h06, 15'h00c0, 4'h0, 1'b0);
		`CK({redef_sel_q, redef_index_q}, 7'h60)
		wr(OCR_OFF_PAGE, 32'h00);
		px(6'h06, 15'h0085, 4'h0, 1'b0);
		`CK(redef_sel_q, 1'b0)
		// teletext colours for every alphanumeric colour code and new background
		wr(OCR_OFF_CTRL, 32'h01);
		px(6'h07, 15'h0041, 4'h7, 1'b0);
		// a teletext row holds forty cells, the forty-first shows video
		for (int i = 1; i < 40; i++) begin
			px(6'h06, 15'h0041, 4'h7, 1'b0);
		end
		px(6'h06, 15'h0041, 4'h0, 1'b1);
		for (int c = 0; c < 8; c++) begin
			px(6'h03, {7'h00, 8'(c)}, 4'h8, 1'b0);
			px(6'h02, 15'h001d, 4'h8 + 4'(c), 1'b0);
			px(6'h06, 15'h0041, 4'(c), 1'b0);
		end
		// teletext meshes
		wr(OCR_OFF_PAGE, 32'h04);
		px(6'h23, 15'h0041, 4'h0, 1'b1);
		px(6'h02, 15'h0001, 4'h8, 1'b0);
		px(6'h22, 15'h001d, 4'h9, 1'b0);
		wr(OCR_OFF_PAGE, 32'h10);
		px(6'h22, 15'h0041, 4'h0, 1'b1);
		// teletext fringe on alphanumerics only
		wr(OCR_OFF_PAGE, 32'h01);
		wr(OCR_OFF_FRINGE, 32'hc1);
		rd(OCR_OFF_FRINGE, 32'hc1, 2'b00);
		fringe_nbr <= 4'h1;
		px(6'h03, 15'h0041, 4'hc, 1'b0);
		fringe_nbr <= 4'h2;
		px(6'h02, 15'h0041, 4'h8, 1'b0);
		fringe_nbr <= 4'h0;
		px(6'h02, 15'h0011, 4'h8, 1'b0);
		fringe_nbr <= 4'h1;
		px(6'h02, 15'h0061, 4'h8, 1'b0);
		conclude();
	end
endmodule
